//--- common/bsc_pkg.sv
// constants and types shared by the tester status, count and pattern block
package bsc_pkg;
    // host port addresses
    localparam logic [9:0] ADR_CTRL1   = 10'h2f0;
    localparam logic [9:0] ADR_CTRL2   = 10'h2f1;
    localparam logic [9:0] ADR_CTRL4   = 10'h2f3;
    localparam logic [9:0] ADR_END_LO  = 10'h2f4;
    localparam logic [9:0] ADR_END_HI  = 10'h2f5;
    localparam logic [9:0] ADR_STATUS  = 10'h2f6;
    localparam logic [9:0] ADR_TAPSEED = 10'h2f8;
    localparam logic [9:0] ADR_COUNT   = 10'h2e8;
    localparam logic [9:0] ADR_MEM     = 10'h2ff;
    localparam logic [2:0] COUNT_BYTES = 3'h6;
    // control bit positions
    localparam int CR1_SEED_LOAD = 0;
    localparam int CR1_REP_MODE  = 2;
    localparam int CR1_LATCH     = 5;
    localparam int CR2_RX_INV    = 4;
    localparam int CR2_TX_INV    = 5;
    localparam int CR4_SEED_SEL  = 1;
    localparam int CR4_COUNT_SEL = 2;
    localparam int CR4_MEM_HOST  = 3;
    localparam int CR4_MEM_READ  = 4;
    // widths and depths
    localparam int CNT_W  = 48;
    localparam int TAP_W  = 32;
    localparam int MEM_AW = 9;
    localparam int MEM_DEPTH = 512;
    // values after reset
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [31:0] TAP_RST  = 32'h0000_0000;
    localparam logic [31:0] SEED_RST = 32'hffff_ffff;
    // cycle counts on the receive clock
    localparam logic [5:0] ALL_RUN  = 6'h28;
    localparam logic [5:0] SYNC_RUN = 6'h20;
    localparam logic [2:0] LOS_ERRS = 3'h4;
    // checker states
    typedef enum logic [1:0] {
        SY_HUNT   = 2'b01,
        SY_LOCKED = 2'b10
    } bsc_sync_e;
endpackage

//--- hw/bsc_sync.sv
// two-flop synchroniser bank for levels and toggles
`timescale 1ns/10ps
module bsc_sync #(
    parameter int W = 1
) (
    // destination clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

//--- hw/bsc_top.sv
// tester status flags, bit and error counts, pattern setup and pattern memory
// How it works
// - latched status bits hold until status read
// - bit 0 shows live sync state
// - bit 1 set while hunting, held until read
// - bit 2 flags bit counter overflow
// - bit 3 flags error counter overflow
// - bit 4 flags new errors, read clears
// - bit 5 set after forty zeros, prbs
// - bit 6 set after forty ones, prbs
// - read clears loss and run flags once ended
// - tap bits set feedback and length
// - control 4 bit 1 picks tap or seed
// - seed load edge loads transmit register
// - control 4 bit 2 picks count bank
// - bit counter counts every enabled clock outside latch edges
// - bit counter wraps and flags overflow
// - error counter counts mismatches while synced
// - latch edge snapshots then clears accumulators
// - memory owned by host only when selected
// - select rising edge zeroes memory pointer
// - memory write stores, strobe end advances
// - latch counts acts on rising edge only
// - read select picks memory read or write
`timescale 1ns/10ps
module bsc_top (
    // core clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    // host parallel port
    input  wire logic [9:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // framer port on the receive line clock
    input  wire logic       rx_clk_i,
    input  wire logic       rx_clk_en_i,
    input  wire logic       rx_data_i,
    output logic            tx_data_o
);
    localparam int CFG_W = 2 * bsc_pkg::TAP_W + 3;

    logic [1:0] rst_sy_r;
    logic       rst_n;
    logic [1:0] rx_rst_sy_r;
    logic       rx_rst_n;

    // reset release through two flops in each domain
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sy_r <= 2'h0;
        end else begin
            rst_sy_r <= {rst_sy_r[0], 1'b1};
        end
    end
    always_ff @(posedge rx_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_rst_sy_r <= 2'h0;
        end else begin
            rx_rst_sy_r <= {rx_rst_sy_r[0], 1'b1};
        end
    end
    assign rst_n    = rst_sy_r[1];
    assign rx_rst_n = rx_rst_sy_r[1];

    // ---------------- core domain registers ----------------
    logic [7:0]  cr1_r, cr2_r, cr4_r, end_lo_r, end_hi_r;
    logic [31:0] tap_r, seed_r;
    logic        wr_d_r, rd_d_r;
    logic        latch_tgl_r, seed_tgl_r;
    logic        st_lost_r, st_bovf_r, st_eovf_r, st_err_r;
    logic        st_az_r, st_a1_r;
    logic [47:0] bit_cnt_r, err_cnt_r;
    logic [8:0]  ptr_r;
    logic [7:0]  mem [0:bsc_pkg::MEM_DEPTH-1];
    logic        snap_seen_r, bovf_seen_r, eovf_seen_r, errv_seen_r;

    // strobe edges and address decode
    wire wr_rise   = wr_i & ~wr_d_r;
    wire wr_fall   = ~wr_i & wr_d_r;
    wire rd_rise   = rd_i & ~rd_d_r;
    wire rd_fall   = ~rd_i & rd_d_r;
    wire hit_mem   = addr_i == bsc_pkg::ADR_MEM;
    wire hit_stat  = addr_i == bsc_pkg::ADR_STATUS;
    wire hit_ts    = addr_i[9:2] == bsc_pkg::ADR_TAPSEED[9:2];
    wire [2:0] cidx = addr_i[2:0];
    wire hit_cnt   = addr_i[9:3] == bsc_pkg::ADR_COUNT[9:3]
                     && cidx < bsc_pkg::COUNT_BYTES;
    wire host_sel  = cr4_r[bsc_pkg::CR4_MEM_HOST];
    wire mem_rdsel = cr4_r[bsc_pkg::CR4_MEM_READ];
    wire seed_sel  = cr4_r[bsc_pkg::CR4_SEED_SEL];
    wire cnt_sel   = cr4_r[bsc_pkg::CR4_COUNT_SEL];
    wire [7:0] cr1_nxt = (wr_rise && addr_i == bsc_pkg::ADR_CTRL1)
                         ? wdata_i : cr1_r;
    wire [7:0] cr4_nxt = (wr_rise && addr_i == bsc_pkg::ADR_CTRL4)
                         ? wdata_i : cr4_r;
    wire mem_we    = host_sel & ~mem_rdsel & wr_rise & hit_mem;
    wire mem_step  = host_sel & hit_mem & (wr_fall | rd_fall);
    wire host_rise = cr4_nxt[bsc_pkg::CR4_MEM_HOST] & ~host_sel;
    wire rd_clr    = rd_rise & hit_stat;

    // control and pattern registers written by the host
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cr1_r    <= bsc_pkg::CTRL_RST;
            cr2_r    <= bsc_pkg::CTRL_RST;
            cr4_r    <= bsc_pkg::CTRL_RST;
            end_lo_r <= bsc_pkg::CTRL_RST;
            end_hi_r <= bsc_pkg::CTRL_RST;
            tap_r    <= bsc_pkg::TAP_RST;
            seed_r   <= bsc_pkg::SEED_RST;
            wr_d_r   <= 1'b0;
            rd_d_r   <= 1'b0;
        end else begin
            wr_d_r <= wr_i;
            rd_d_r <= rd_i;
            cr1_r  <= cr1_nxt;
            cr4_r  <= cr4_nxt;
            if (wr_rise && addr_i == bsc_pkg::ADR_CTRL2) begin
                cr2_r <= wdata_i;
            end
            if (wr_rise && addr_i == bsc_pkg::ADR_END_LO) begin
                end_lo_r <= wdata_i;
            end
            if (wr_rise && addr_i == bsc_pkg::ADR_END_HI) begin
                end_hi_r <= wdata_i;
            end
            if (wr_rise && hit_ts && !seed_sel) begin
                tap_r[addr_i[1:0]*8 +: 8] <= wdata_i;
            end
            if (wr_rise && hit_ts && seed_sel) begin
                seed_r[addr_i[1:0]*8 +: 8] <= wdata_i;
            end
        end
    end

    // rising edges of latch and seed load become toggles for the link side
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            latch_tgl_r <= 1'b0;
            seed_tgl_r  <= 1'b0;
        end else begin
            if (cr1_nxt[bsc_pkg::CR1_LATCH] && !cr1_r[bsc_pkg::CR1_LATCH]) begin
                latch_tgl_r <= ~latch_tgl_r;
            end
            if (cr1_nxt[bsc_pkg::CR1_SEED_LOAD]
                && !cr1_r[bsc_pkg::CR1_SEED_LOAD]) begin
                seed_tgl_r <= ~seed_tgl_r;
            end
        end
    end

    // pattern memory, written only under host ownership
    always_ff @(posedge core_clk_i) begin
        if (mem_we) begin
            mem[ptr_r] <= wdata_i;
        end
    end

    // indirect pointer: cleared on select rise, stepped at strobe end
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= 9'h000;
        end else if (host_rise) begin
            ptr_r <= 9'h000;
        end else if (mem_step) begin
            ptr_r <= ptr_r + 9'h001;
        end
    end

    // ---------------- link domain ----------------
    logic [CFG_W-1:0] cfg_s;
    logic [1:0]       tgl_s;
    logic             latch_prev_r, seed_prev_r;
    logic             rx_bit_r;
    logic [31:0]      chk_r, tx_sr_r;
    bsc_pkg::bsc_sync_e sy_r;
    logic [5:0]       good_run_r, zero_run_r, one_run_r;
    logic [2:0]       bad_run_r;
    logic [47:0]      bit_acc_r, err_acc_r, bit_snap_r, err_snap_r;
    logic             snap_tgl_r, bovf_tgl_r, eovf_tgl_r, errv_tgl_r;
    logic             tx_out_r;

    bsc_sync #(.W(CFG_W)) u_cfg_sync (
        .clk_i   (rx_clk_i),
        .rst_n_i (rx_rst_n),
        .d_i     ({tap_r, seed_r, cr2_r[bsc_pkg::CR2_RX_INV],
                   cr2_r[bsc_pkg::CR2_TX_INV],
                   cr1_r[bsc_pkg::CR1_REP_MODE]}),
        .q_o     (cfg_s)
    );
    bsc_sync #(.W(2)) u_tgl_sync (
        .clk_i   (rx_clk_i),
        .rst_n_i (rx_rst_n),
        .d_i     ({latch_tgl_r, seed_tgl_r}),
        .q_o     (tgl_s)
    );

    wire [31:0] tap_l  = cfg_s[CFG_W-1 -: 32];
    wire [31:0] seed_l = cfg_s[CFG_W-33 -: 32];
    wire rx_inv   = cfg_s[2];
    wire tx_inv   = cfg_s[1];
    wire rep_mode = cfg_s[0];
    wire latch_ev = tgl_s[1] ^ latch_prev_r;
    wire seed_ev  = tgl_s[0] ^ seed_prev_r;
    wire din      = rx_bit_r ^ rx_inv;
    wire exp_bit  = ^(chk_r & tap_l);
    wire bit_err  = din ^ exp_bit;
    wire locked   = sy_r == bsc_pkg::SY_LOCKED;
    wire count_err = rx_clk_en_i & locked & bit_err;
    wire [48:0] bit_sum = {1'b0, bit_acc_r} + 49'h0_0000_0000_0001;
    wire [48:0] err_sum = {1'b0, err_acc_r} + 49'h0_0000_0000_0001;
    wire tx_fb    = ^(tx_sr_r & tap_l);

    // sample line data and track the latch and seed toggles
    always_ff @(posedge rx_clk_i or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            rx_bit_r     <= 1'b0;
            latch_prev_r <= 1'b0;
            seed_prev_r  <= 1'b0;
        end else begin
            rx_bit_r     <= rx_data_i;
            latch_prev_r <= tgl_s[1];
            seed_prev_r  <= tgl_s[0];
        end
    end

    // pattern checker: hunt on received bits, free-run once locked
    always_ff @(posedge rx_clk_i or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            sy_r       <= bsc_pkg::SY_HUNT;
            chk_r      <= 32'h0000_0000;
            good_run_r <= 6'h00;
            bad_run_r  <= 3'h0;
        end else if (rx_clk_en_i) begin
            case (sy_r)
                bsc_pkg::SY_HUNT: begin
                    chk_r      <= {chk_r[30:0], din};
                    good_run_r <= bit_err ? 6'h00 : good_run_r + 6'h01;
                    bad_run_r  <= 3'h0;
                    if (!bit_err && good_run_r == bsc_pkg::SYNC_RUN) begin
                        sy_r <= bsc_pkg::SY_LOCKED;
                    end
                end
                bsc_pkg::SY_LOCKED: begin
                    chk_r      <= {chk_r[30:0], exp_bit};
                    good_run_r <= 6'h00;
                    bad_run_r  <= bit_err ? bad_run_r + 3'h1 : 3'h0;
                    if (bit_err && bad_run_r == bsc_pkg::LOS_ERRS - 3'h1) begin
                        sy_r <= bsc_pkg::SY_HUNT;
                    end
                end
                default: sy_r <= bsc_pkg::SY_HUNT;
            endcase
        end
    end

    // runs of equal bits for the all-zero and all-one flags
    always_ff @(posedge rx_clk_i or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            zero_run_r <= 6'h00;
            one_run_r  <= 6'h00;
        end else if (rx_clk_en_i) begin
            zero_run_r <= din ? 6'h00 : (zero_run_r == bsc_pkg::ALL_RUN)
                          ? zero_run_r : zero_run_r + 6'h01;
            one_run_r  <= !din ? 6'h00 : (one_run_r == bsc_pkg::ALL_RUN)
                          ? one_run_r : one_run_r + 6'h01;
        end
    end

    // accumulators, snapshot on latch, overflow and error toggles
    always_ff @(posedge rx_clk_i or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            bit_acc_r  <= 48'h0000_0000_0000;
            err_acc_r  <= 48'h0000_0000_0000;
            bit_snap_r <= 48'h0000_0000_0000;
            err_snap_r <= 48'h0000_0000_0000;
            snap_tgl_r <= 1'b0;
            bovf_tgl_r <= 1'b0;
            eovf_tgl_r <= 1'b0;
            errv_tgl_r <= 1'b0;
        end else begin
            if (latch_ev) begin
                bit_snap_r <= bit_acc_r;
                err_snap_r <= err_acc_r;
                bit_acc_r  <= 48'h0000_0000_0000;
                err_acc_r  <= 48'h0000_0000_0000;
                snap_tgl_r <= ~snap_tgl_r;
            end else begin
                if (rx_clk_en_i) begin
                    bit_acc_r <= bit_sum[47:0];
                end
                if (count_err) begin
                    err_acc_r <= err_sum[47:0];
                end
            end
            if (rx_clk_en_i && bit_sum[48]) begin
                bovf_tgl_r <= ~bovf_tgl_r;
            end
            if (count_err && err_sum[48]) begin
                eovf_tgl_r <= ~eovf_tgl_r;
            end
            if (count_err) begin
                errv_tgl_r <= ~errv_tgl_r;
            end
        end
    end

    // transmit pattern register, seed loaded on request
    always_ff @(posedge rx_clk_i or negedge rx_rst_n) begin
        if (!rx_rst_n) begin
            tx_sr_r  <= bsc_pkg::SEED_RST;
            tx_out_r <= 1'b0;
        end else if (seed_ev) begin
            tx_sr_r <= seed_l;
        end else if (rx_clk_en_i) begin
            tx_sr_r  <= {tx_sr_r[30:0], tx_fb};
            tx_out_r <= tx_fb ^ tx_inv;
        end
    end
    assign tx_data_o = tx_out_r;

    // ---------------- back to the core domain ----------------
    logic [7:0] st_s;
    bsc_sync #(.W(8)) u_st_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .d_i     ({snap_tgl_r, bovf_tgl_r, eovf_tgl_r, errv_tgl_r, locked,
                   !locked, !rep_mode && zero_run_r == bsc_pkg::ALL_RUN,
                   !rep_mode && one_run_r == bsc_pkg::ALL_RUN}),
        .q_o     (st_s)
    );
    wire snap_ev = st_s[7] ^ snap_seen_r;
    wire bovf_ev = st_s[6] ^ bovf_seen_r;
    wire eovf_ev = st_s[5] ^ eovf_seen_r;
    wire errv_ev = st_s[4] ^ errv_seen_r;
    wire sync_s  = st_s[3];
    wire los_s   = st_s[2];
    wire az_s    = st_s[1];
    wire a1_s    = st_s[0];

    // sticky flags: a new set wins over a read clear
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            {snap_seen_r, bovf_seen_r, eovf_seen_r, errv_seen_r} <= 4'h0;
            {st_lost_r, st_bovf_r, st_eovf_r, st_err_r} <= 4'h0;
            {st_az_r, st_a1_r} <= 2'h0;
            bit_cnt_r <= 48'h0000_0000_0000;
            err_cnt_r <= 48'h0000_0000_0000;
        end else begin
            {snap_seen_r, bovf_seen_r, eovf_seen_r, errv_seen_r} <= st_s[7:4];
            st_lost_r <= los_s | (st_lost_r & ~rd_clr);
            st_bovf_r <= bovf_ev | (st_bovf_r & ~rd_clr);
            st_eovf_r <= eovf_ev | (st_eovf_r & ~rd_clr);
            st_err_r  <= errv_ev | (st_err_r & ~rd_clr);
            st_az_r   <= az_s | (st_az_r & ~rd_clr);
            st_a1_r   <= a1_s | (st_a1_r & ~rd_clr);
            if (snap_ev) begin
                bit_cnt_r <= bit_snap_r;
                err_cnt_r <= err_snap_r;
            end
        end
    end

    // read data selection
    wire [7:0]  status_w = {1'b0, st_a1_r, st_az_r, st_err_r, st_eovf_r,
                            st_bovf_r, st_lost_r, sync_s};
    wire [31:0] ts_w   = seed_sel ? seed_r : tap_r;
    wire [47:0] cnt_w  = cnt_sel ? err_cnt_r : bit_cnt_r;
    wire [7:0]  mem_rd = (host_sel && mem_rdsel) ? mem[ptr_r] : 8'h00;
    wire [7:0]  rd_mux =
        hit_stat ? status_w :
        hit_ts   ? ts_w[addr_i[1:0]*8 +: 8] :
        hit_cnt  ? cnt_w[cidx*8 +: 8] :
        hit_mem  ? mem_rd :
        (addr_i == bsc_pkg::ADR_CTRL1)  ? cr1_r :
        (addr_i == bsc_pkg::ADR_CTRL2)  ? cr2_r :
        (addr_i == bsc_pkg::ADR_CTRL4)  ? cr4_r :
        (addr_i == bsc_pkg::ADR_END_LO) ? end_lo_r :
        (addr_i == bsc_pkg::ADR_END_HI) ? end_hi_r : 8'h00;

    // read data captured at the read strobe's leading edge
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 8'h00;
        end else if (rd_rise) begin
            rdata_o <= rd_mux;
        end
    end

    // checks on the core side
    sync_live_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        rd_clr |=> rdata_o[0] == $past(sync_s)) else $error("sync bit stale");
    lost_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        st_lost_r && !rd_clr |=> st_lost_r) else $error("loss flag dropped");
    bovf_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        bovf_ev |=> st_bovf_r ##1 (st_bovf_r || $past(rd_clr)))
        else $error("bit overflow not flagged");
    eovf_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        eovf_ev |=> st_eovf_r) else $error("error overflow not flagged");
    err_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        rd_clr && !errv_ev |=> !st_err_r) else $error("error flag not cleared");
    persist_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        rd_clr && (az_s || los_s) |=> st_az_r || st_lost_r)
        else $error("flag cleared while condition holds");
    ptr_reset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        host_rise |=> ptr_r == 9'h000) else $error("pointer not reset");
    ptr_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        mem_step && !host_rise |=> ptr_r == $past(ptr_r) + 9'h001)
        else $error("pointer not stepped");
    mem_owner_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        !host_sel |-> !mem_we) else $error("memory written while owned");
    // checks on the link side, then covers on both sides
    bit_count_a: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        rx_clk_en_i && !latch_ev |=> bit_acc_r == $past(bit_acc_r) + 48'h1)
        else $error("bit count missed");
    err_freeze_a: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        !locked && !latch_ev |=> $stable(err_acc_r))
        else $error("errors counted out of sync");
    latch_clear_a: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        latch_ev |=> bit_snap_r == $past(bit_acc_r) && err_acc_r == 48'h0)
        else $error("latch did not snapshot");
    lock_c: cover property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        $rose(locked));
    mem_wr_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
        mem_we ##[1:20] mem_step);
    snap_c: cover property (@(posedge core_clk_i) disable iff (!rst_n)
        snap_ev && bit_snap_r != 48'h0);
endmodule

//--- testbench/bsc_framer_model.sv
// framer port model: loops the generated pattern back, with line faults
`timescale 1ns/10ps
module bsc_framer_model (
    // receive line clock and pattern from the block
    input  wire logic       rx_clk_i,
    input  wire logic       tx_bit_i,
    input  wire logic [1:0] mode_i,
    // toward the block
    output logic            rx_en_o = 1'b0,
    output logic            rx_data_o = 1'b0
);
    // mode 0 loops, 1 all zeros, 2 all ones, 3 inverts the looped bit
    always_ff @(posedge rx_clk_i) begin
        rx_en_o <= 1'b1;
        case (mode_i)
            2'd1: rx_data_o <= 1'b0;
            2'd2: rx_data_o <= 1'b1;
            2'd3: rx_data_o <= ~tx_bit_i;
            default: rx_data_o <= tx_bit_i;
        endcase
    end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the tester status, count and pattern block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
 $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    logic       clk = 1'b0;
    logic       rx_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       rx_en;
    logic       rx_data;
    logic       tx_data;
    logic [1:0] mode = 2'd0;
    int         fails = 0;
    int         tests_run = 0;
    // core clock 100 ns and unrelated link clock 160 ns
    initial forever #50 clk = ~clk;
    initial begin
        #37;
        forever #80 rx_clk = ~rx_clk;
    end
    bsc_top uut (.core_clk_i(clk), .resetn_i(resetn), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .rx_clk_i(rx_clk), .rx_clk_en_i(rx_en), .rx_data_i(rx_data),
        .tx_data_o(tx_data));
    bsc_framer_model far (.rx_clk_i(rx_clk), .tx_bit_i(tx_data),
        .mode_i(mode), .rx_en_o(rx_en), .rx_data_o(rx_data));
    // host write: strobe one cycle, dropped before the next access
    task automatic hw(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask
    // host read: data taken once the registered answer has landed
    task automatic hr(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        rd = 1'b1;
        repeat (2) @(posedge clk);
        #1 d = rdata;
        rd = 1'b0;
    endtask
    task automatic t_regs();
        logic [7:0] d;
        hr(bsc_pkg::ADR_TAPSEED, d);
        `CHK("tap0", 8'h00, d)
        hw(bsc_pkg::ADR_CTRL4, 8'h02);
        hr(bsc_pkg::ADR_TAPSEED + 10'h003, d);
        `CHK("seed3", 8'hff, d)
        hw(bsc_pkg::ADR_CTRL4, 8'h00);
        hw(bsc_pkg::ADR_END_LO, 8'h02);
        hr(bsc_pkg::ADR_END_LO, d);
        `CHK("end_lo", 8'h02, d)
        hr(10'h100, d);
        `CHK("unmapped", 8'h00, d)
    endtask
    // memory load then read-back with the select bit held
    task automatic t_mem();
        logic [7:0] d;
        hw(bsc_pkg::ADR_CTRL4, 8'h08);
        for (int i = 0; i < 3; i++) hw(bsc_pkg::ADR_MEM, 8'ha5 ^ 8'(i));
        hw(bsc_pkg::ADR_CTRL4, 8'h00);
        hw(bsc_pkg::ADR_CTRL4, 8'h18);
        for (int i = 0; i < 3; i++) begin
            hr(bsc_pkg::ADR_MEM, d);
            `CHK("mem", 8'ha5 ^ 8'(i), d)
        end
        hw(bsc_pkg::ADR_CTRL4, 8'h00);
        hr(bsc_pkg::ADR_MEM, d);
        `CHK("mem_owned", 8'h00, d)
    endtask
    // pattern seeded and looped back, then one bit flipped on the line
    task automatic t_sync();
        logic [7:0] s;
        hw(bsc_pkg::ADR_TAPSEED, 8'h41);
        hw(bsc_pkg::ADR_CTRL1, 8'h01);
        repeat (200) @(posedge clk);
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("sync_lost", 2'b11, s[1:0])
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("sync_live", 2'b01, s[1:0])
        // clear the accumulators so only the injected error is counted
        hw(bsc_pkg::ADR_CTRL1, 8'h21);
        repeat (20) @(posedge clk);
        @(posedge rx_clk);
        #1 mode = 2'd3;
        @(posedge rx_clk);
        #1 mode = 2'd0;
        repeat (20) @(posedge clk);
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("err_seen", 2'b11, {s[4], s[0]})
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("err_clr", 1'b0, s[4])
    endtask
    // snapshot, then a second snapshot shows the cleared accumulator
    task automatic t_latch();
        logic [7:0] d;
        hw(bsc_pkg::ADR_CTRL1, 8'h00);
        hw(bsc_pkg::ADR_CTRL1, 8'h20);
        repeat (20) @(posedge clk);
        hw(bsc_pkg::ADR_CTRL4, 8'h04);
        hr(bsc_pkg::ADR_COUNT, d);
        `CHK("err_cnt", 8'h01, d)
        hw(bsc_pkg::ADR_CTRL1, 8'h00);
        hw(bsc_pkg::ADR_CTRL1, 8'h20);
        repeat (20) @(posedge clk);
        hr(bsc_pkg::ADR_COUNT, d);
        `CHK("err_cnt_clr", 8'h00, d)
        hw(bsc_pkg::ADR_CTRL4, 8'h00);
        hr(bsc_pkg::ADR_COUNT + 10'h005, d);
        `CHK("bit_cnt_hi", 8'h00, d)
    endtask
    // long runs of zeros then ones; flags survive a read while they last
    task automatic t_runs();
        logic [7:0] s;
        for (int v = 1; v < 3; v++) begin
            #1 mode = 2'(v);
            // zeros relock the checker, ones never do
            repeat (400) @(posedge clk);
            hr(bsc_pkg::ADR_STATUS, s);
            `CHK("run", 1'b1, s[4 + v])
            hr(bsc_pkg::ADR_STATUS, s);
            `CHK("run_held", (v == 1) ? 3'b101 : 3'b110, {s[4 + v], s[1:0]})
            #1 mode = 2'd0;
        end
    endtask
    // line inverts: receive alone breaks sync, both together cancel
    task automatic t_inv();
        logic [7:0] s;
        hw(bsc_pkg::ADR_CTRL2, 8'h10);
        repeat (100) @(posedge clk);
        hr(bsc_pkg::ADR_STATUS, s);
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("rx_inv", 2'b10, s[1:0])
        hw(bsc_pkg::ADR_CTRL2, 8'h30);
        repeat (200) @(posedge clk);
        hr(bsc_pkg::ADR_STATUS, s);
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("both_inv", 2'b01, s[1:0])
        hw(bsc_pkg::ADR_CTRL2, 8'h00);
        repeat (200) @(posedge clk);
        hr(bsc_pkg::ADR_STATUS, s);
        hr(bsc_pkg::ADR_STATUS, s);
        `CHK("inv_off", 1'b1, s[0])
    endtask
    task automatic print_verdict();
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #2_000_000;
        fails++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (5) @(posedge clk);
        t_regs();
        t_mem();
        t_sync();
        t_latch();
        t_inv();
        t_runs();
        print_verdict();
    end
endmodule
